// *** src/ddr_mode_burst.sv ***
`timescale 1ns/100ps
`default_nettype none

module ddr_mode_burst
    import ddr_mode_burst_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              ck,
    input  wire logic              ck_n,
    input  wire ddr_cmd_s          cmd,
    input  wire logic [`DQ_W-1:0]  dq_in,
    output logic      [`DQ_W-1:0]  dq_out,
    output logic                   dq_oe,
    input  wire logic              dqs_in,
    output logic                   dqs_out,
    output logic                   dqs_oe,
    input  wire logic              dm,
    output mode_status_s           mode_status,
    output logic      [3:0]        bank_open,
    output logic                   busy
);

    typedef struct packed {
        // synced ck and strobe levels for edge finding
        logic                          ck_hi;
        logic                          dqs;
        // sequencer, mode word and open rows
        burst_state_e                  st;
        logic [`ADDR_W-1:0]            mode;
        logic                          dll_rst;
        logic [3:0]                    bank_open;
        logic [3:0][`ADDR_W-1:0]       row;
        // burst progress and target
        logic [2:0]                    hcnt;
        logic [3:0]                    beat;
        logic [1:0]                    bank;
        logic [`COL_W-1:0]             col;
        logic                          ap;
        // odd read beat and even write beat held for pairing
        logic [`DQ_W-1:0]              rd_hi;
        logic [`DQ_W-1:0]              wr_lo;
        logic                          wr_lo_m;
        // pin drivers
        logic [`DQ_W-1:0]              dq;
        logic                          dq_oe;
        logic                          dqs_o;
        logic                          dqs_oe;
    } state_s;

    state_s              r_r;
    state_s              r_nxt;
    link_pins_s          pins;
    logic [$bits(link_pins_s)-1:0] pins_q;
    // a small slice of each bank only; see the index below
    logic [`DQ_W-1:0]    mem [0:(1<<`MEM_AW)-1];

    logic                ck_hi_now;
    logic                ck_rise;
    logic                half;
    logic                dqs_edge;
    logic                sel;
    logic [2:0]          code;
    logic [2:0]          bl_mask;
    logic [3:0]          bl_beats;
    logic [2:0]          lat_half;
    logic [2:0]          bl_code;
    logic [2:0]          lat_code;
    logic [1:0][2:0]     pair_base;
    logic [1:0][2:0]     pair_off;
    logic [2:0]          off_a;
    logic [2:0]          off_b;
    logic [`MEM_AW-1:0]  idx_a;
    logic [`MEM_AW-1:0]  idx_b;
    logic [`DQ_W-1:0]    rd_a;
    logic [`DQ_W-1:0]    rd_b;
    logic                we_pair;
    logic [`DQ_W-1:0]    wd_a;
    logic [`DQ_W-1:0]    wd_b;
    logic                wm_a;
    logic                wm_b;
    logic [6:0]          op_field;

    // every pin, ck included, is foreign to clk and passes two flops
    pin_sync #(
        .W ($bits(link_pins_s))
    ) u_sync (
        .clk   (clk),
        .reset (reset),
        .d     ({ck, ck_n, cmd, dq_in, dqs_in, dm}),
        .q     (pins_q)
    );

    assign pins = link_pins_s'(pins_q);

    // the pair of columns handled this step: even beat and the one after
    for (genvar g = 0; g < 2; g++) begin : g_order
        assign pair_base[g] = {r_r.beat[2:1], 1'(g)};

        burst_order u_order (
            .start      (r_r.col[2:0]),
            .beat       (pair_base[g]),
            .mask       (bl_mask),
            .interleave (r_r.mode[`MODE_BT_BIT]),
            .col        (pair_off[g])
        );
    end

    assign off_a = pair_off[0];
    assign off_b = pair_off[1];

    // upper column bits select the block; only low bits move
    assign idx_a = {r_r.bank, r_r.row[r_r.bank][1:0], r_r.col[5:3], off_a};
    assign idx_b = {r_r.bank, r_r.row[r_r.bank][1:0], r_r.col[5:3], off_b};
    assign rd_a  = mem[idx_a];
    assign rd_b  = mem[idx_b];

    // field slices of the stored mode word
    assign bl_code  = r_r.mode[`MODE_BL_MSB:`MODE_BL_LSB];
    assign lat_code = r_r.mode[`MODE_LAT_MSB:`MODE_LAT_LSB];

    // decode of the stored mode word
    always_comb begin
        op_field = r_r.mode[`MODE_OP_MSB:`MODE_OP_LSB];
        unique case (bl_code)
            `BL_CODE_2: bl_mask = `BL_MASK_2;
            `BL_CODE_4: bl_mask = `BL_MASK_4;
            `BL_CODE_8: bl_mask = `BL_MASK_8;
            // reserved codes run as eight; flagged on the status port
            default:    bl_mask = `BL_MASK_8;
        endcase
        bl_beats = {1'b0, bl_mask} + 4'h1;
        // latency in ck half cycles
        unique case (lat_code)
            `LAT_CODE_25: lat_half = `CL25_HALF;
            // reserved latency codes run as two clocks
            default:      lat_half = `CL2_HALF;
        endcase
    end

    always_comb begin
        r_nxt     = r_r;
        // both legs must agree for high, so one leg moving alone is no rise, though it does end a high half
        ck_hi_now = pins.ck & ~pins.ck_n;
        ck_rise   = ck_hi_now & ~r_r.ck_hi;
        half      = ck_hi_now != r_r.ck_hi;
        // dqs edges while the controller owns the strobe
        dqs_edge  = (pins.dqs != r_r.dqs) & ~r_r.dqs_oe;
        sel       = ck_rise & ~pins.cmd.cs_n;
        code      = {pins.cmd.ras_n, pins.cmd.cas_n, pins.cmd.we_n};
        we_pair   = 1'b0;
        wd_a      = r_r.wr_lo;
        wd_b      = pins.dq;
        wm_a      = r_r.wr_lo_m;
        wm_b      = pins.dm;

        r_nxt.ck_hi   = ck_hi_now;
        r_nxt.dqs     = pins.dqs;
        r_nxt.dll_rst = 1'b0;
        // loaded value lives for one cycle only
        r_nxt.mode[`MODE_DLL_BIT] = 1'b0;

        // command decode on each detected ck rise
        if (sel) begin
            unique case (code)
                `CMD_ACT: begin
                    r_nxt.bank_open[pins.cmd.ba] = 1'b1;
                    r_nxt.row[pins.cmd.ba]       = pins.cmd.addr;
                end
                `CMD_PRE: begin
                    if (pins.cmd.addr[`AP_BIT]) begin
                        r_nxt.bank_open = 4'h0;
                    end else begin
                        r_nxt.bank_open[pins.cmd.ba] = 1'b0;
                    end
                end
                `CMD_MRS: begin
                    // array untouched; refused while a burst runs
                    if (pins.cmd.ba == 2'h0 && r_r.st == ST_IDLE) begin
                        r_nxt.mode    = pins.cmd.addr;
                        r_nxt.dll_rst = pins.cmd.addr[`MODE_OP_MSB:`MODE_OP_LSB]
                                        == `OP_DLL_RESET;
                    end
                end
                `CMD_READ,
                `CMD_WRITE: begin
                    // relies on the row having been opened first
                    if (r_r.st == ST_IDLE) begin
                        r_nxt.bank = pins.cmd.ba;
                        r_nxt.col  = {pins.cmd.addr[11], pins.cmd.addr[9:0]};
                        r_nxt.ap   = pins.cmd.addr[`AP_BIT];
                        r_nxt.beat = 4'h0;
                        r_nxt.hcnt = lat_half;
                        r_nxt.st   = (code == `CMD_READ) ? ST_RD_WAIT : ST_WR_DATA;
                    end
                end
                default: begin
                end
            endcase
        end

        // burst sequencing; reads step on every ck half edge
        unique case (r_r.st)
            ST_IDLE: begin
            end
            ST_RD_WAIT: begin
                if (half) begin
                    r_nxt.hcnt = r_r.hcnt - 3'h1;
                    if (r_r.hcnt == 3'h2) begin
                        // preamble: drive strobe low half a clock early
                        r_nxt.dqs_oe = 1'b1;
                        r_nxt.dqs_o  = 1'b0;
                    end
                    if (r_r.hcnt == 3'h1) begin
                        r_nxt.dq    = rd_a;
                        r_nxt.rd_hi = rd_b;
                        r_nxt.dq_oe = 1'b1;
                        r_nxt.dqs_o = 1'b1;
                        r_nxt.beat  = 4'h1;
                        r_nxt.st    = ST_RD_DATA;
                    end
                end
            end
            ST_RD_DATA: begin
                if (half) begin
                    if (r_r.beat == bl_beats) begin
                        r_nxt.dq_oe  = 1'b0;
                        r_nxt.dqs_oe = 1'b0;
                        r_nxt.dqs_o  = 1'b0;
                        r_nxt.st     = ST_IDLE;
                        if (r_r.ap) begin
                            r_nxt.bank_open[r_r.bank] = 1'b0;
                        end
                    end else begin
                        if (!r_r.beat[0]) begin
                            r_nxt.dq    = rd_a;
                            r_nxt.rd_hi = rd_b;
                        end else begin
                            r_nxt.dq    = r_r.rd_hi;
                        end
                        // strobe flips in the same flop update as data
                        r_nxt.dqs_o = ~r_r.dqs_o;
                        r_nxt.beat  = r_r.beat + 4'h1;
                    end
                end
            end
            ST_WR_DATA: begin
                if (dqs_edge) begin
                    r_nxt.beat = r_r.beat + 4'h1;
                    // even beat waits for its odd partner, then both land
                    if (!r_r.beat[0]) begin
                        r_nxt.wr_lo   = pins.dq;
                        r_nxt.wr_lo_m = pins.dm;
                    end else begin
                        we_pair = 1'b1;
                        if (r_r.beat + 4'h1 == bl_beats) begin
                            r_nxt.st = ST_IDLE;
                            if (r_r.ap) begin
                                r_nxt.bank_open[r_r.bank] = 1'b0;
                            end
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            r_r      <= '0;
            r_r.mode <= `MODE_RST;
        end else begin
            r_r <= r_nxt;
        end
    end

    // array has no reset, so mode changes and resets never disturb it
    always_ff @(posedge clk) begin
        if (we_pair) begin
            if (!wm_a) begin
                mem[idx_a] <= wd_a;
            end
            if (!wm_b) begin
                mem[idx_b] <= wd_b;
            end
        end
    end

    // every output here comes straight from a flop, except busy, which is decoded from the state flops
    assign dq_out    = r_r.dq;
    assign dq_oe     = r_r.dq_oe;
    assign dqs_out   = r_r.dqs_o;
    assign dqs_oe    = r_r.dqs_oe;
    assign bank_open = r_r.bank_open;
    assign busy      = r_r.st != ST_IDLE;

    always_comb begin
        mode_status.mode_word    = r_r.mode;
        mode_status.dll_reset    = r_r.dll_rst;
        // reserved settings still run; the flags let the controller see them
        mode_status.op_reserved  = 1'b1;
        mode_status.bl_reserved  = 1'b1;
        mode_status.lat_reserved = 1'b1;

        if (op_field == `OP_NORMAL || op_field == `OP_DLL_RESET) begin
            mode_status.op_reserved = 1'b0;
        end

        if (bl_code == `BL_CODE_2 || bl_code == `BL_CODE_4 || bl_code == `BL_CODE_8) begin
            mode_status.bl_reserved = 1'b0;
        end

        if (lat_code == `LAT_CODE_2 || lat_code == `LAT_CODE_25) begin
            mode_status.lat_reserved = 1'b0;
        end
    end

endmodule // ddr_mode_burst

`default_nettype wire

// *** src/ddr_mode_burst_cfg.svh ***
`ifndef DDR_MODE_BURST_CFG_SVH
`define DDR_MODE_BURST_CFG_SVH

// widths
`define DQ_W            8
`define ADDR_W          14
`define COL_W           11
`define MEM_AW          10

// mode word layout and reset value
`define MODE_RST        14'h0022
`define MODE_BL_LSB     0
`define MODE_BL_MSB     2
`define MODE_BT_BIT     3
`define MODE_LAT_LSB    4
`define MODE_LAT_MSB    6
`define MODE_OP_LSB     7
`define MODE_OP_MSB     13
`define MODE_DLL_BIT    8

// burst length codes and block masks
`define BL_CODE_2       3'h1
`define BL_CODE_4       3'h2
`define BL_CODE_8       3'h3
`define BL_MASK_2       3'h1
`define BL_MASK_4       3'h3
`define BL_MASK_8       3'h7

// read latency codes and their length in ck half cycles
`define LAT_CODE_2      3'h2
`define LAT_CODE_25     3'h6
`define CL2_HALF        3'h4
`define CL25_HALF       3'h5

// operating mode field values
`define OP_NORMAL       7'h00
`define OP_DLL_RESET    7'h02

// command codes as {ras_n, cas_n, we_n}
`define CMD_MRS         3'h0
`define CMD_PRE         3'h2
`define CMD_ACT         3'h3
`define CMD_WRITE       3'h4
`define CMD_READ        3'h5

// address line carrying auto precharge / all-bank precharge
`define AP_BIT          10

`endif

// *** src/ddr_mode_burst_pkg.sv ***
package ddr_mode_burst_pkg;

`include "ddr_mode_burst_cfg.svh"

    typedef struct packed {
        logic                cs_n;
        logic                ras_n;
        logic                cas_n;
        logic                we_n;
        logic [1:0]          ba;
        logic [`ADDR_W-1:0]  addr;
    } ddr_cmd_s;

    typedef struct packed {
        logic                ck;
        logic                ck_n;
        ddr_cmd_s            cmd;
        logic [`DQ_W-1:0]    dq;
        logic                dqs;
        logic                dm;
    } link_pins_s;

    typedef struct packed {
        logic [`ADDR_W-1:0]  mode_word;
        logic                dll_reset;
        logic                op_reserved;
        logic                bl_reserved;
        logic                lat_reserved;
    } mode_status_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RD_WAIT,
        ST_RD_DATA,
        ST_WR_DATA
    } burst_state_e;

endpackage

// *** src/pin_sync.sv ***
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_s;

    sync_s r_r;
    sync_s r_nxt;

    // first stage feeds only the second
    always_comb begin
        r_nxt    = r_r;
        r_nxt.s1 = d;
        r_nxt.s2 = r_r.s1;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign q = r_r.s2;

endmodule // pin_sync

`default_nettype wire

// *** src/burst_order.sv ***
`timescale 1ns/100ps
`default_nettype none

module burst_order (
    input  wire logic [2:0] start,
    input  wire logic [2:0] beat,
    input  wire logic [2:0] mask,
    input  wire logic       interleave,
    output logic      [2:0] col
);

    logic [2:0] sum;

    always_comb begin
        sum = start + beat;
        // bits outside the block mask stay with the start column
        if (interleave) begin
            col = ((start ^ beat) & mask) | (start & ~mask);
        end else begin
            col = (sum & mask) | (start & ~mask);
        end
    end

endmodule // burst_order

`default_nettype wire

// *** sim/ddr_mode_burst_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "ddr_mode_burst_cfg.svh"
module ddr_mode_burst_monitor
    import ddr_mode_burst_pkg::*;
(
    input wire logic             clk,
    input wire logic             reset,
    input wire logic [`DQ_W-1:0] dq_out,
    input wire logic             dq_oe,
    input wire logic             dqs_out,
    input wire logic             dqs_oe,
    input wire mode_status_s     mode_status,
    input wire logic             busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic [13:0] mw;
    assign mw = mode_status.mode_word;
    dqs_read_only_a: assert property (dqs_oe |-> busy)
        else $error("strobe driven outside a burst");
    oe_release_a: assert property ($fell(dq_oe) |-> !dqs_oe && !dqs_out && !busy)
        else $error("read pins not released together");
    edge_align_a: assert property (dq_oe && $past(dq_oe) && $changed(dq_out) |-> $changed(dqs_out))
        else $error("read data moved without strobe");
    beat_width_a: assert property ($rose(dqs_out) |=> $stable(dqs_out)[*2] ##[1:3] !dqs_out)
        else $error("read beat not one half cycle");
    preamble_len_a: assert property ($rose(dqs_oe) |-> !dq_oe ##1 !dq_oe[*2] ##[1:3] dq_oe)
        else $error("preamble not one half cycle");
    mode_idle_a: assert property ({mw[13:9], mw[7:0]} != $past({mw[13:9], mw[7:0]}) |-> !$past(busy))
        else $error("mode changed during a burst");
    dll_self_clear_a: assert property ($rose(mw[8]) |=> !mw[8])
        else $error("dll bit did not clear");
    dll_pulse_a: assert property (mode_status.dll_reset |-> mw[13:7] == `OP_DLL_RESET ##1 !mode_status.dll_reset)
        else $error("dll reset pulse wrong");
    field_decode_a: assert property (mode_status.bl_reserved == !(mw[2:0] inside {3'h1, 3'h2, 3'h3})
        && mode_status.lat_reserved == !(mw[6:4] inside {3'h2, 3'h6})
        && mode_status.op_reserved == !(mw[13:7] inside {7'h00, 7'h02}))
        else $error("mode field decode wrong");
    cover property ($rose(dq_oe));
    cover property ($rose(mode_status.dll_reset));
    cover property ($fell(busy) && !dqs_oe);
endmodule // ddr_mode_burst_monitor
bind ddr_mode_burst ddr_mode_burst_monitor mon_u (.clk(clk), .reset(reset), .dq_out(dq_out), .dq_oe(dq_oe),
    .dqs_out(dqs_out), .dqs_oe(dqs_oe), .mode_status(mode_status), .busy(busy));
`default_nettype wire

// *** sim/ddr_ctrl_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module ddr_ctrl_model
    import ddr_mode_burst_pkg::*;
(
    output logic       ck,
    output logic       ck_n,
    output ddr_cmd_s   cmd,
    output logic [7:0] dq_in,
    output logic       dqs_in,
    output logic       dm
);
    realtime t_rise;
    assign ck_n = ~ck;
    // free running, offset so its edges never meet clk edges
    initial begin
        ck = 1'b0;
        cmd = '1;
        dq_in = 8'h00;
        dqs_in = 1'b0;
        dm = 1'b0;
        #33;
        forever #80 ck = ~ck;
    end
    // command held across exactly one rising ck edge
    task issue(input logic [2:0] c, input logic [1:0] ba, input logic [13:0] a);
        @(negedge ck) #1;
        cmd = {1'b0, c, ba, a};
        @(posedge ck) t_rise = $realtime;
        @(negedge ck) #1;
        cmd = ~cmd;
    endtask
    task write(input logic [1:0] ba, input logic [13:0] a, input int n, input logic [7:0] d0,
               input logic [7:0] mask);
        issue(3'h4, ba, a);
        for (int i = 0; i < n; i++) begin
            dq_in = d0 + 8'(i);
            dm = mask[i];
            #40 dqs_in = ~dqs_in; // strobe edge mid window
            #40;
        end
        dq_in = ~dq_in;
        dm = 1'b0;
    endtask
endmodule // ddr_ctrl_model
`default_nettype wire

// *** sim/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench
    import ddr_mode_burst_pkg::*;
;
    logic         clk, reset, ck, ck_n, dm, dqs_in, dq_oe, dqs_out, dqs_oe, busy, oe_q, dqs_q;
    ddr_cmd_s     cmd;
    logic [7:0]   dq_in, dq_out, beats[$];
    mode_status_s ms;
    logic [3:0]   bank_open;
    logic [2:0]   bl, lat, st, half, c, blk_mask;
    logic         bt;
    logic [12:0]  rows [7];
    int           n_errors, cmp_count, dll_seen, n;
    realtime      t_oe, dt;
    ddr_mode_burst dut_u (.clk(clk), .reset(reset), .ck(ck), .ck_n(ck_n), .cmd(cmd), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe), .dqs_in(dqs_in), .dqs_out(dqs_out), .dqs_oe(dqs_oe), .dm(dm),
        .mode_status(ms), .bank_open(bank_open), .busy(busy));
    ddr_ctrl_model ctrl_u (.ck(ck), .ck_n(ck_n), .cmd(cmd), .dq_in(dq_in), .dqs_in(dqs_in), .dm(dm));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // a beat is taken whenever the read strobe moves
    always @(posedge clk) begin
        if (dq_oe && (!oe_q || dqs_out != dqs_q)) beats.push_back(dq_out);
        if (dq_oe && !oe_q) t_oe = $realtime;
        if (ms.dll_reset === 1'b1) dll_seen++;
        oe_q <= dq_oe;
        dqs_q <= dqs_out;
    end
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task summarize;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task wait_idle;
        int k;
        k = 0;
        @(posedge clk);
        while (busy !== 1'b0 && k < 300) begin
            @(posedge clk);
            k++;
        end
        if (k >= 300) begin
            n_errors++;
            summarize;
        end
        repeat (2) @(posedge clk);
    endtask
    task rd_chk(input logic [13:0] a, input logic [7:0] e0, input logic [7:0] e1, input logic [7:0] e2,
                input logic [7:0] e3);
        beats.delete();
        ctrl_u.issue(3'h5, 2'h0, a);
        wait_idle;
        chk(16'(beats.size()), 16'h0004);
        chk({beats[0], beats[1]}, {e0, e1});
        chk({beats[2], beats[3]}, {e2, e3});
    endtask
    initial begin
        // {length, type, latency, start, expected latency in half ck}
        rows = '{{3'h1, 1'h0, 3'h2, 3'h1, 3'h4}, {3'h2, 1'h0, 3'h2, 3'h3, 3'h4}, {3'h2, 1'h1, 3'h6, 3'h1, 3'h5},
                 {3'h3, 1'h0, 3'h6, 3'h5, 3'h5}, {3'h3, 1'h1, 3'h2, 3'h6, 3'h4}, {3'h3, 1'h1, 3'h6, 3'h3, 3'h5},
                 {3'h1, 1'h1, 3'h6, 3'h0, 3'h5}};
        n_errors = 0;
        cmp_count = 0;
        dll_seen = 0;
        oe_q = 1'b0;
        dqs_q = 1'b0;
        reset = 1'b1;
        repeat (4) @(posedge clk);
        #2 reset = 1'b0;
        chk(ms.mode_word, 16'h0022);
        ctrl_u.issue(3'h0, 2'h0, 14'h0023);
        ctrl_u.issue(3'h3, 2'h0, 14'h0000);
        chk(bank_open, 16'h0001);
        ctrl_u.write(2'h0, 14'h0000, 8, 8'h10, 8'h00);
        wait_idle;
        foreach (rows[r]) begin
            {bl, bt, lat, st, half} = rows[r];
            ctrl_u.issue(3'h0, 2'h0, {7'h00, lat, bt, bl});
            n = 1 << bl;
            blk_mask = 3'(n - 1);
            beats.delete();
            ctrl_u.issue(3'h5, 2'h0, {11'h000, st});
            wait_idle;
            dt = t_oe - ctrl_u.t_rise;
            chk(16'(beats.size()), 16'(n));
            chk(16'(dt >= half * 80 && dt <= half * 80 + 100), 16'h0001);
            for (int i = 0; i < n; i++) begin
                c = bt ? st ^ 3'(i) : (st & ~blk_mask) | ((st + 3'(i)) & blk_mask);
                chk(16'(beats[i]), 16'(8'h10 + c));
            end
        end
        ctrl_u.issue(3'h0, 2'h0, 14'h0022);
        ctrl_u.write(2'h0, 14'h0404, 4, 8'h40, 8'h02);
        wait_idle;
        chk(bank_open, 16'h0000);
        ctrl_u.issue(3'h3, 2'h0, 14'h0000);
        rd_chk(14'h0004, 8'h40, 8'h15, 8'h42, 8'h43);
        beats.delete();
        ctrl_u.issue(3'h5, 2'h0, 14'h0006);
        ctrl_u.issue(3'h0, 2'h0, 14'h0023);
        wait_idle;
        chk(ms.mode_word, 16'h0022);
        chk({beats[0], beats[1]}, 16'h4243);
        ctrl_u.issue(3'h0, 2'h1, 14'h0031);
        chk(ms.mode_word, 16'h0022);
        ctrl_u.issue(3'h0, 2'h0, 14'h0122);
        chk(ms.mode_word, 16'h0022);
        chk(16'(dll_seen), 16'h0001);
        ctrl_u.issue(3'h0, 2'h0, 14'h0420);
        chk({ms.bl_reserved, ms.op_reserved, ms.lat_reserved}, 16'h0006);
        ctrl_u.issue(3'h3, 2'h2, 14'h0155);
        chk(bank_open, 16'h0005);
        ctrl_u.issue(3'h2, 2'h2, 14'h0000);
        chk(bank_open, 16'h0001);
        ctrl_u.issue(3'h2, 2'h1, 14'h0400);
        chk(bank_open, 16'h0000);
        ctrl_u.issue(3'h3, 2'h1, 14'h0000);
        @(posedge clk) #2 reset = 1'b1;
        repeat (4) @(posedge clk);
        chk({bank_open, busy, dq_oe, dqs_oe, dqs_out}, 16'h0000);
        chk(ms.mode_word, 16'h0022);
        #2 reset = 1'b0;
        summarize;
    end
endmodule // testbench
`default_nettype wire
